/* rtl/dif_pkg.sv */
// Constants for the digital input function router.
`default_nettype none
package dif_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SELMAP  = 8'h00;
  localparam logic [7:0] ADDR_FUNMAP  = 8'h04;
  localparam logic [7:0] ADDR_CFG     = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_CAPTURE = 8'h10;
  // ---------------------------------------------------------------
  // Source codes and input capabilities
  // ---------------------------------------------------------------
  localparam int         NUM_IN       = 9;
  localparam int         SEL_BITS     = 8;
  localparam logic [3:0] NO_INPUT     = 4'hF;
  localparam logic [3:0] LAST_INPUT   = 4'h8;
  localparam logic [3:0] IN_ENABLE    = 4'h5;
  localparam logic [3:0] IN_LIMIT_NEG = 4'h6;
  localparam logic [3:0] IN_LIMIT_POS = 4'h7;
  localparam logic [3:0] IN_FAST_A    = 4'h4;
  localparam logic [3:0] IN_FAST_B    = 4'h8;
  localparam logic [8:0] OK_GENERAL   = 9'h01F;
  localparam logic [8:0] OK_SAMPLE    = 9'h100;
  localparam logic [8:0] OK_FAST      = 9'h110;
  // ---------------------------------------------------------------
  // Field positions of the function map, config and status
  // ---------------------------------------------------------------
  localparam int FN_START  = 0;
  localparam int FN_REF    = 4;
  localparam int FN_SAMPLE = 8;
  localparam int FN_STOP   = 12;
  localparam int FN_JOGNEG = 16;
  localparam int FN_JOGPOS = 20;
  localparam int FN_HOME   = 24;
  localparam int FUN_W     = 28;
  localparam int CFG_STOP_POL = 0;
  localparam int CFG_REF_LSB  = 1;
  localparam int ST_CAP_VALID = 0;
  localparam int ST_REJECTED  = 1;
  localparam int ST_RAW_LSB   = 16;
  // ---------------------------------------------------------------
  // Reset values, homing reference choices and bus responses
  // ---------------------------------------------------------------
  localparam logic [31:0]     SELMAP_RST = 32'hFFFF_3210;
  localparam logic [FUN_W-1:0] FUNMAP_RST = 28'hFFF_F884;
  localparam logic [2:0]      CFG_RST    = 3'h1;
  localparam logic [1:0]      REF_SWITCH = 2'h0;
  localparam logic [1:0]      REF_LIMNEG = 2'h1;
  localparam logic [1:0]      REF_LIMPOS = 2'h2;
  localparam logic [1:0]      RESP_OKAY  = 2'h0;
  localparam logic [1:0]      RESP_DECERR = 2'h3;
endpackage : dif_pkg
`default_nettype wire

/* rtl/dif_in_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module dif_in_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit only moves once stages two and three agree.
  always_ff @(posedge clk)
  begin
    if (rst)
      syncOut <= '0;
    else
      syncOut <= (stage2_reg & ~(stage2_reg ^ stage3_reg)) | (syncOut & (stage2_reg ^ stage3_reg));
  end
endmodule : dif_in_sync
`default_nettype wire

/* rtl/dif_router.sv */
// Digital input function router with AXI4-Lite configuration.
// Operation
// RL1: Mapped selector inputs form an 8-bit index picking one of 256 targets.
// RL2: Default map: inputs 0-3 select bits 0-3, input 4 starts positioning.
// RL3: Only fast input eight may latch the actual position.
// RL4: Negative and positive limit switches restrict travel.
// RL5: Homing reference may be the switch or either limit switch.
// RL6: Power stage enabled only with enable input and both torque cutoff inputs.
// RL7: Enable and limits are fixed; other functions are freely mappable.
// RL8: Mappings to unsuitable inputs are rejected.
// RL9: Each function names at most one source input.
// RL10: One input may drive several functions at once.
// RL11: Multiple use of one input raises no error.
// RL12: Jog negative and jog positive have separate mappable inputs.
// RL13: Digital stop halts positioning and speed control.
// RL14: Active sample edge stores the actual position.
// RL15: Free inputs feed start, reference and others through per-function selectors.
// RL16: Selectors on 0-4, sample on 8, start/reference on 4 or 8, 5-7 fixed.
// RL17: Outside controller drives homing start and reference through mapped inputs.
// RL18: Every pin input is synchronised before mapping or edge detection.
// RL19: Unmapped selector bits read as zero in the index.
`timescale 1ns/1ps
`default_nettype none
module dif_router (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [8:0]  din,
  input  wire logic [1:0]  torqueCutoffInputs,
  input  wire logic [31:0] actualPos,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [7:0]  targetIndex,
  output var  logic        posStart,
  output var  logic        homeStart,
  output var  logic        refSwitch,
  output var  logic        homeReference,
  output var  logic        limitNeg,
  output var  logic        limitPos,
  output var  logic        powerStageEn,
  output var  logic        haltPositioning,
  output var  logic        haltSpeed,
  output var  logic        jogNeg,
  output var  logic        jogPos,
  output var  logic [31:0] capturedPos
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic pick(input logic [8:0] v, input logic [3:0] c);
    pick = (c <= dif_pkg::LAST_INPUT) ? v[c] : 1'b0;
  endfunction : pick

  function automatic logic legal(input logic [3:0] c, input logic [8:0] ok);
    legal = (c == dif_pkg::NO_INPUT) || ((c <= dif_pkg::LAST_INPUT) && ok[c]);
  endfunction : legal

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [8:0]  pins;
  logic [1:0]  cutoffSync;
  logic [8:0]  pinsPrev_reg;

  dif_in_sync #(.W(11)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({torqueCutoffInputs, din}),
    .syncOut ({cutoffSync, pins})
  ); // see RL18

  always_ff @(posedge clk)
  begin
    if (rst)
      pinsPrev_reg <= '0;
    else
      pinsPrev_reg <= pins;
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [31:0]              selMap_reg;
  logic [dif_pkg::FUN_W-1:0] funMap_reg;
  logic [2:0]               cfg_reg;
  logic                     rejected_reg;
  logic                     capValid_reg;
  logic                     awHeld_reg;
  logic                     wHeld_reg;
  logic [7:0]               awAddr_reg;
  logic [31:0]              wData_reg;
  logic [3:0]               wStrb_reg;
  logic                     awTake;
  logic                     wTake;
  logic                     doWrite;
  logic [7:0]               wrAddr;
  logic [31:0]              wrData;
  logic [3:0]               wrStrb;
  logic [31:0]              oldVal;
  logic [31:0]              merged;
  logic                     selOk;
  logic                     funOk;

  assign awready = !awHeld_reg && !bvalid;
  assign wready  = !wHeld_reg && !bvalid;
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;
  assign doWrite = (awHeld_reg || awTake) && (wHeld_reg || wTake);
  assign wrAddr  = awHeld_reg ? awAddr_reg : awaddr;
  assign wrData  = wHeld_reg ? wData_reg : wdata;
  assign wrStrb  = wHeld_reg ? wStrb_reg : wstrb;

  always_comb
  begin
    case (wrAddr)
      dif_pkg::ADDR_SELMAP: oldVal = selMap_reg;
      dif_pkg::ADDR_FUNMAP: oldVal = {4'h0, funMap_reg};
      default:              oldVal = {29'h0, cfg_reg};
    endcase
    for (int b = 0; b < 4; b++)
      merged[8*b +: 8] = wrStrb[b] ? wrData[8*b +: 8] : oldVal[8*b +: 8];
  end

  // One nibble per function means one source at most; duplicates across
  // functions are allowed and not flagged.
  always_comb
  begin
    selOk = 1'b1;
    for (int i = 0; i < dif_pkg::SEL_BITS; i++)
      selOk = selOk && legal(merged[4*i +: 4], dif_pkg::OK_GENERAL); // see RL8 see RL16
    funOk = legal(merged[dif_pkg::FN_START +: 4], dif_pkg::OK_FAST)
         && legal(merged[dif_pkg::FN_REF +: 4], dif_pkg::OK_FAST)
         && legal(merged[dif_pkg::FN_SAMPLE +: 4], dif_pkg::OK_SAMPLE) // see RL3
         && legal(merged[dif_pkg::FN_STOP +: 4], dif_pkg::OK_GENERAL)
         && legal(merged[dif_pkg::FN_JOGNEG +: 4], dif_pkg::OK_GENERAL)
         && legal(merged[dif_pkg::FN_JOGPOS +: 4], dif_pkg::OK_GENERAL)
         && legal(merged[dif_pkg::FN_HOME +: 4], dif_pkg::OK_GENERAL)
         && (merged[31:dif_pkg::FUN_W] == 4'h0); // see RL9 see RL11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
    end
    else
    begin
      if (awTake)
      begin
        awAddr_reg <= awaddr;
      end
      if (wTake)
      begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      awHeld_reg <= (awHeld_reg || awTake) && !doWrite;
      wHeld_reg  <= (wHeld_reg || wTake) && !doWrite;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      selMap_reg   <= dif_pkg::SELMAP_RST; // see RL2
      funMap_reg   <= dif_pkg::FUNMAP_RST;
      cfg_reg      <= dif_pkg::CFG_RST;
      rejected_reg <= 1'b0;
    end
    else if (doWrite)
    begin
      case (wrAddr)
        dif_pkg::ADDR_SELMAP:
        begin
          if (selOk)
            selMap_reg <= merged;
          rejected_reg <= !selOk; // see RL8
        end
        dif_pkg::ADDR_FUNMAP:
        begin
          if (funOk)
            funMap_reg <= merged[dif_pkg::FUN_W-1:0];
          rejected_reg <= !funOk; // see RL8
        end
        dif_pkg::ADDR_CFG:
          cfg_reg <= merged[2:0];
        default:
          rejected_reg <= rejected_reg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= dif_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp  <= (wrAddr == dif_pkg::ADDR_SELMAP || wrAddr == dif_pkg::ADDR_FUNMAP
                 || wrAddr == dif_pkg::ADDR_CFG || wrAddr == dif_pkg::ADDR_STATUS)
                ? dif_pkg::RESP_OKAY : dif_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign arready = !rvalid;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= dif_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= dif_pkg::RESP_OKAY;
      case (araddr)
        dif_pkg::ADDR_SELMAP:  rdata <= selMap_reg;
        dif_pkg::ADDR_FUNMAP:  rdata <= {4'h0, funMap_reg};
        dif_pkg::ADDR_CFG:     rdata <= {29'h0, cfg_reg};
        dif_pkg::ADDR_STATUS:  rdata <= {7'h0, pins, 14'h0, rejected_reg, capValid_reg};
        dif_pkg::ADDR_CAPTURE: rdata <= capturedPos;
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= dif_pkg::RESP_DECERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Function routing
  // ---------------------------------------------------------------
  logic       startLvl;
  logic       startPrev;
  logic       homeLvl;
  logic       homePrev;
  logic       sampleRise;
  logic       stopLvl;
  logic [7:0] indexNext;
  logic       clearCap;

  assign startLvl   = pick(pins, funMap_reg[dif_pkg::FN_START +: 4]); // see RL15
  assign startPrev  = pick(pinsPrev_reg, funMap_reg[dif_pkg::FN_START +: 4]);
  assign homeLvl    = pick(pins, funMap_reg[dif_pkg::FN_HOME +: 4]);
  assign homePrev   = pick(pinsPrev_reg, funMap_reg[dif_pkg::FN_HOME +: 4]);
  assign sampleRise = pick(pins, funMap_reg[dif_pkg::FN_SAMPLE +: 4])
                      && !pick(pinsPrev_reg, funMap_reg[dif_pkg::FN_SAMPLE +: 4]);
  assign stopLvl    = pick(pins, funMap_reg[dif_pkg::FN_STOP +: 4])
                      == cfg_reg[dif_pkg::CFG_STOP_POL]
                      && funMap_reg[dif_pkg::FN_STOP +: 4] != dif_pkg::NO_INPUT;
  assign clearCap   = doWrite && wrAddr == dif_pkg::ADDR_STATUS && wrStrb[0]
                      && wrData[dif_pkg::ST_CAP_VALID];

  always_comb
  begin
    for (int i = 0; i < dif_pkg::SEL_BITS; i++)
      indexNext[i] = pick(pins, selMap_reg[4*i +: 4]); // see RL1 see RL19
  end

  // Every routed output is computed from the same synchronised vector, so
  // functions sharing an input change in the same cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      targetIndex     <= 8'h00;
      posStart        <= 1'b0;
      homeStart       <= 1'b0;
      refSwitch       <= 1'b0;
      jogNeg          <= 1'b0;
      jogPos          <= 1'b0;
      haltPositioning <= 1'b0;
      haltSpeed       <= 1'b0;
    end
    else
    begin
      targetIndex     <= indexNext;
      posStart        <= startLvl && !startPrev; // see RL10
      homeStart       <= homeLvl && !homePrev;
      refSwitch       <= pick(pins, funMap_reg[dif_pkg::FN_REF +: 4]);
      jogNeg          <= pick(pins, funMap_reg[dif_pkg::FN_JOGNEG +: 4]); // see RL12
      jogPos          <= pick(pins, funMap_reg[dif_pkg::FN_JOGPOS +: 4]);
      haltPositioning <= stopLvl; // see RL13
      haltSpeed       <= stopLvl;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      limitNeg      <= 1'b0;
      limitPos      <= 1'b0;
      powerStageEn  <= 1'b0;
      homeReference <= 1'b0;
    end
    else
    begin
      limitNeg     <= pins[dif_pkg::IN_LIMIT_NEG]; // see RL4 see RL7
      limitPos     <= pins[dif_pkg::IN_LIMIT_POS];
      powerStageEn <= pins[dif_pkg::IN_ENABLE] && (&cutoffSync); // see RL6
      case (cfg_reg[dif_pkg::CFG_REF_LSB +: 2])
        dif_pkg::REF_LIMNEG: homeReference <= pins[dif_pkg::IN_LIMIT_NEG]; // see RL5
        dif_pkg::REF_LIMPOS: homeReference <= pins[dif_pkg::IN_LIMIT_POS];
        default:             homeReference <= pick(pins, funMap_reg[dif_pkg::FN_REF +: 4]);
      endcase
    end
  end

  // A new sample wins over a same-cycle clear of the valid flag.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      capturedPos  <= 32'h0000_0000;
      capValid_reg <= 1'b0;
    end
    else if (sampleRise)
    begin
      capturedPos  <= actualPos; // see RL14
      capValid_reg <= 1'b1;
    end
    else if (clearCap)
      capValid_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_power_gate: assert property ( // see RL6
    ##1 powerStageEn == $past(pins[dif_pkg::IN_ENABLE] && (&cutoffSync)))
    else $error("power stage enable does not follow enable and cutoff inputs");
  chk_limit_fixed: assert property ( // see RL4
    ##1 limitNeg == $past(pins[dif_pkg::IN_LIMIT_NEG]) && limitPos == $past(pins[dif_pkg::IN_LIMIT_POS]))
    else $error("limit outputs not tied to inputs six and seven");
  chk_index_form: assert property (##1 targetIndex == $past(indexNext)) // see RL1
    else $error("target index not formed from mapped inputs");
  chk_unmapped_zero: assert property (selMap_reg[31:28] == dif_pkg::NO_INPUT |=> !targetIndex[7]) // see RL19
    else $error("unmapped selector bit reads nonzero");
  chk_sample_only: assert property ( // see RL3
    legal(funMap_reg[dif_pkg::FN_SAMPLE +: 4], dif_pkg::OK_SAMPLE))
    else $error("sample mapped to an unsuitable input");
  chk_sel_legal: assert property ( // see RL16
    legal(selMap_reg[3:0], dif_pkg::OK_GENERAL) && legal(funMap_reg[dif_pkg::FN_START +: 4], dif_pkg::OK_FAST))
    else $error("selector or start mapped to an unsuitable input");
  chk_capture_pos: assert property (sampleRise |=> capturedPos == $past(actualPos) && capValid_reg) // see RL14
    else $error("sample edge did not store the position");
  chk_stop_both: assert property (haltPositioning == haltSpeed) // see RL13
    else $error("digital stop halts only one process");
  chk_reject_map: assert property (doWrite && wrAddr == dif_pkg::ADDR_FUNMAP && !funOk |=> $stable(funMap_reg)
                                   && rejected_reg) // see RL8
    else $error("illegal mapping was accepted");
  chk_start_pulse: assert property (posStart |=> !posStart) // see RL15
    else $error("start pulse longer than one cycle");

  cov_capture: cover property (sampleRise ##1 capValid_reg);
  cov_reject: cover property (doWrite && !funOk && wrAddr == dif_pkg::ADDR_FUNMAP);
  cov_shared: cover property (posStart && homeStart);
endmodule : dif_router
`default_nettype wire

/* verif/dif_pin_model.sv */
// Model of the switches, sensors and host lines that drive the input pins.
`timescale 1ns/1ps
`default_nettype none
module dif_pin_model (
  input  wire logic        clk,
  input  wire logic [8:0]  pinCmd,
  input  wire logic [1:0]  cutCmd,
  input  wire logic [31:0] posCmd,
  output wire logic [8:0]  din,
  output wire logic [1:0]  torqueCutoffInputs,
  output wire logic [31:0] actualPos
);
  logic [8:0]  pinReg = 9'h000;
  logic [1:0]  cutReg = 2'h0;
  logic [31:0] posReg = 32'h0000_0000;

  // Lines move only at clock edges, so every level lasts whole cycles.
  always @(posedge clk)
  begin
    pinReg <= pinCmd;
    cutReg <= cutCmd;
    posReg <= posCmd;
  end

  assign din                = pinReg;
  assign torqueCutoffInputs = cutReg;
  assign actualPos          = posReg;
endmodule : dif_pin_model
`default_nettype wire

/* verif/test_dif_router.sv */
// Self-checking testbench of the digital input function router.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errTotal++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_dif_router;
  logic        clk;
  logic        rst;
  logic [8:0]  pinCmd;
  logic [1:0]  cutCmd;
  logic [31:0] posCmd;
  wire  [8:0]  din;
  wire  [1:0]  cut;
  wire  [31:0] pos;
  logic [7:0]  awaddr, araddr, targetIndex;
  logic [31:0] wdata, rdata, capturedPos, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        posStart, homeStart, refSwitch, homeReference, limitNeg, limitPos;
  logic        powerStageEn, haltPositioning, haltSpeed, jogNeg, jogPos;
  int          errTotal = 0;
  int          checks   = 0;
  int          cycles   = 0;
  int          posCnt   = 0;
  int          homeCnt  = 0;
  logic [3:0]  strb     = 4'hF;
  logic [8:0]  srcMask [3] = '{9'h010, 9'h040, 9'h080};

  dif_pin_model pins_u (.clk(clk), .pinCmd(pinCmd), .cutCmd(cutCmd), .posCmd(posCmd),
    .din(din), .torqueCutoffInputs(cut), .actualPos(pos));

  dif_router dut_u (.clk(clk), .rst(rst), .din(din), .torqueCutoffInputs(cut), .actualPos(pos),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .targetIndex(targetIndex), .posStart(posStart),
    .homeStart(homeStart), .refSwitch(refSwitch), .homeReference(homeReference),
    .limitNeg(limitNeg), .limitPos(limitPos), .powerStageEn(powerStageEn),
    .haltPositioning(haltPositioning), .haltSpeed(haltSpeed), .jogNeg(jogNeg), .jogPos(jogPos),
    .capturedPos(capturedPos));

  // ---------------------------------------------------------------
  // Clock, pulse counters and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task report_and_stop();
    $display("Counts: checks=%0d errors=%0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // The run needs a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    if (posStart === 1'b1)
      posCnt++;
    if (homeStart === 1'b1)
      homeCnt++;
    cycles++;
    if (cycles == 20000)
    begin
      errTotal++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Register bus and pin tasks
  // ---------------------------------------------------------------
  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (aw && awready === 1'b1)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (ar && arready === 1'b1)
      begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  task chk_reg(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rsp);
    `CHK(rd, e);
    `CHK(rsp, dif_pkg::RESP_OKAY);
  endtask : chk_reg

  task wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    `CHK(rsp, dif_pkg::RESP_OKAY);
  endtask : wr_ok

  // Pins pass a synchroniser and an agreement filter, so each change is given time to settle.
  task set_pins(input logic [8:0] p);
    pinCmd <= p;
    repeat (10) @(posedge clk);
  endtask : set_pins

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    pinCmd = 9'h000;
    cutCmd = 2'h0;
    posCmd = 32'h0000_0000;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(targetIndex, 8'h00);
    `CHK(powerStageEn, 1'b0);
    chk_reg(dif_pkg::ADDR_SELMAP, 32'hFFFF_3210);
    chk_reg(dif_pkg::ADDR_FUNMAP, 32'h0FFF_F884);
    chk_reg(dif_pkg::ADDR_CFG, 32'h0000_0001);
    chk_reg(dif_pkg::ADDR_STATUS, 32'h0000_0000);
    axi_read(8'h14, rd, rsp);
    `CHK(rd, 32'h0000_0000);
    `CHK(rsp, dif_pkg::RESP_DECERR);
    axi_write(8'h18, 32'hFFFF_FFFF, rsp);
    `CHK(rsp, dif_pkg::RESP_DECERR);
    set_pins(9'h00A);
    `CHK(targetIndex, 8'h0A);
    wr_ok(dif_pkg::ADDR_SELMAP, 32'hFFF4_3210);
    set_pins(9'h01A);
    `CHK(targetIndex, 8'h1A);
    `CHK(posCnt, 1);
    wr_ok(dif_pkg::ADDR_SELMAP, 32'hFFFF_3215);
    chk_reg(dif_pkg::ADDR_SELMAP, 32'hFFF4_3210);
    chk_reg(dif_pkg::ADDR_STATUS, 32'h001A_0002);
    wr_ok(dif_pkg::ADDR_FUNMAP, 32'h0FFF_F484);
    wr_ok(dif_pkg::ADDR_FUNMAP, 32'h0FFF_F880);
    chk_reg(dif_pkg::ADDR_FUNMAP, 32'h0FFF_F884);
    set_pins(9'h000);
    wr_ok(dif_pkg::ADDR_FUNMAP, 32'h0321_0848);
    chk_reg(dif_pkg::ADDR_STATUS, 32'h0000_0000);
    set_pins(9'h001);
    `CHK(haltPositioning, 1'b1);
    `CHK(haltSpeed, 1'b1);
    `CHK(targetIndex, 8'h01);
    set_pins(9'h002);
    `CHK({jogNeg, jogPos, haltSpeed}, 3'b100);
    set_pins(9'h004);
    `CHK({jogNeg, jogPos, haltPositioning}, 3'b010);
    set_pins(9'h008);
    `CHK(homeCnt, 1);
    for (int k = 0; k < 3; k++)
    begin
      wr_ok(dif_pkg::ADDR_CFG, 32'(k * 2 + 1));
      set_pins(srcMask[k]);
      `CHK(homeReference, 1'b1);
      `CHK({refSwitch, limitNeg, limitPos}, {srcMask[k][4], srcMask[k][6], srcMask[k][7]});
      set_pins(9'h0D0 & ~srcMask[k]);
      `CHK(homeReference, 1'b0);
    end
    `CHK(posCnt, 1);
    for (int c = 0; c < 4; c++)
    begin
      cutCmd <= 2'(c);
      set_pins(9'h020);
      `CHK(powerStageEn, 1'(c == 3));
    end
    set_pins(9'h000);
    pinCmd <= 9'h020;
    repeat (2) @(posedge clk);
    `CHK(powerStageEn, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(powerStageEn, 1'b1);
    posCmd <= 32'h1234_ABCD;
    set_pins(9'h000);
    set_pins(9'h100);
    `CHK(capturedPos, 32'h1234_ABCD);
    `CHK(posCnt, 2);
    chk_reg(dif_pkg::ADDR_STATUS, 32'h0100_0001);
    chk_reg(dif_pkg::ADDR_CAPTURE, 32'h1234_ABCD);
    posCmd <= 32'h0BAD_0001;
    set_pins(9'h010);
    `CHK(capturedPos, 32'h1234_ABCD);
    wr_ok(dif_pkg::ADDR_STATUS, 32'h0000_0001);
    chk_reg(dif_pkg::ADDR_STATUS, 32'h0010_0000);
    // Low-active stop: input zero low now halts both processes.
    wr_ok(dif_pkg::ADDR_CFG, 32'h0000_0000);
    `CHK({haltPositioning, haltSpeed}, 2'b11);
    set_pins(9'h011);
    `CHK({haltPositioning, haltSpeed}, 2'b00);
    // A single byte lane replaces only selector bits zero and one.
    strb = 4'h1;
    wr_ok(dif_pkg::ADDR_SELMAP, 32'h0000_0001);
    strb = 4'hF;
    chk_reg(dif_pkg::ADDR_SELMAP, 32'hFFF4_3201);
    `CHK(targetIndex, 8'h12);
    report_and_stop();
  end
endmodule : test_dif_router
`default_nettype wire
